// ===== gcr_top.sv
// global configuration upper half: apb register bank, axis-1 controls, diagnostic pins
// Contract
// - pin1 source 0 drives stall or index info on the stall/index pin, 1 drives compare or axis-0 direction.
// - pin0 source 0 drives driver status on the error pin, 1 drives motion controller status.
// - axis-1 driver disable is active high, 0 enables and 1 disables the axis-1 driver.
// - external step mode turns off the axis-1 internal controller and uses external step/dir inputs.
// - in direct current mode coil A comes from target bits 8:0 and coil B from bits 24:16, signed.
// - in direct current mode coil currents are scaled by hold current and auto regulation is off.
// - hard stop enabled with encoder A high stops all axis-1 steps and forces standstill.
// - hysteresis select 0 gives 1/16 and 1 gives 1/32 for step frequency comparison.
// - index-on-pin set asserts the stall/index pin while axis 1 is at lookup position 0, with pin1 source 0 only.
// - compare combine chooses OR, axis 0, axis 1 or AND of the compare signals for the stall/index pin.
// - interrupt combine chooses OR, axis 0, axis 1 or AND of the interrupts for the error pin.
`default_nettype none
`timescale 1ns/10ps
module gcr_top
   import gcr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire gcr_ctrl_s   ctrl,
   input  wire logic [31:0] axis1_target_position,
   input  wire logic [4:0]  hold_current_scale,
   input  wire logic        axis1_step_input,
   input  wire logic        axis1_direction_input,
   input  wire logic        axis1_encoder_a_input,
   output logic             stall_index_pin,
   output logic             error_status_pin,
   output logic             axis1_driver_disable,
   output logic             axis1_internal_ctrl_enable,
   output logic             axis1_step_out,
   output logic             axis1_dir_out,
   output logic             axis1_standstill,
   output logic      [2:0]  axis1_hyst_shift,
   output logic             axis1_direct_active,
   output logic             axis1_auto_current_enable,
   output logic      [8:0]  axis1_coil_a,
   output logic      [8:0]  axis1_coil_b
);
   // configuration and interrupt registers
   gcr_cfg_s    cfg_ff;
   logic [2:0]  irq_status_ff;
   logic [2:0]  irq_mask_ff;
   logic        irq_ff;

   // apb answer registers
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;

   // output registers
   logic        pin1_ff;
   logic        pin0_ff;
   logic        drv_dis_ff;
   logic        int_en_ff;
   logic        step_ff;
   logic        dir_ff;
   logic        standstill_ff;
   logic [2:0]  hyst_ff;
   logic        direct_ff;
   logic        auto_cur_ff;
   logic [8:0]  coil_a_ff;
   logic [8:0]  coil_b_ff;

   // synchronised pins
   logic        ext_step;
   logic        ext_dir;
   logic        enc_a;

   // combinational next values
   logic        nxt_pin1;
   logic        nxt_pin0;
   logic        hard_stop;
   logic        sel_step;
   logic        sel_dir;
   logic        setup;
   logic        access;
   logic        wr_en;
   logic        addr_ok;
   logic [31:0] nxt_rdata;
   logic [2:0]  irq_events;
   logic [2:0]  irq_clear;

   gcr_sync u_sync_step (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (axis1_step_input),
      .dout    (ext_step)
   );

   gcr_sync u_sync_dir (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (axis1_direction_input),
      .dout    (ext_dir)
   );

   gcr_sync u_sync_enc (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (axis1_encoder_a_input),
      .dout    (enc_a)
   );

   gcr_route u_route (
      .cfg      (cfg_ff),
      .ctrl     (ctrl),
      .nxt_pin1 (nxt_pin1),
      .nxt_pin0 (nxt_pin0)
   );

   // apb phase decode; answer comes in the first access cycle
   always_comb begin
      setup   = psel && !penable;
      access  = psel && penable && pready_ff;
      addr_ok = (paddr == GCR_ADDR_GLOBAL_CONFIGURATION) || (paddr == GCR_ADDR_IRQ_STATUS) ||
                (paddr == GCR_ADDR_IRQ_MASK) || (paddr == GCR_ADDR_STATE);
      wr_en   = access && pwrite && !pslverr_ff;
   end

   // read data mux
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (paddr)
         GCR_ADDR_GLOBAL_CONFIGURATION:      nxt_rdata[GCR_CFG_MSB:GCR_CFG_LSB] = cfg_ff;
         GCR_ADDR_IRQ_STATUS: nxt_rdata[GCR_IRQ_W-1:0] = irq_status_ff;
         GCR_ADDR_IRQ_MASK:   nxt_rdata[GCR_IRQ_W-1:0] = irq_mask_ff;
         GCR_ADDR_STATE: begin
            nxt_rdata[GCR_ST_HARD_STOP] = standstill_ff;
            nxt_rdata[GCR_ST_PIN1]      = pin1_ff;
            nxt_rdata[GCR_ST_PIN0]      = pin0_ff;
            nxt_rdata[GCR_ST_EXT_STEP]  = ext_step;
            nxt_rdata[GCR_ST_EXT_DIR]   = ext_dir;
            nxt_rdata[GCR_ST_ENC_A]     = enc_a;
         end
         default:             nxt_rdata = 32'h0000_0000;
      endcase
   end

   // apb answer: ready for one cycle, data and error captured in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            pslverr_ff <= !addr_ok;
            prdata_ff  <= (!pwrite && addr_ok) ? nxt_rdata : 32'h0000_0000;
         end else if (access) begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // configuration word; fields feed the routing directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= gcr_cfg_s'(GCR_CFG_RST);
      end else if (wr_en && paddr == GCR_ADDR_GLOBAL_CONFIGURATION) begin
         cfg_ff <= gcr_cfg_s'(pwdata[GCR_CFG_MSB:GCR_CFG_LSB]);
      end
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= GCR_IRQ_RST;
      end else if (wr_en && paddr == GCR_ADDR_IRQ_MASK) begin
         irq_mask_ff <= pwdata[GCR_IRQ_W-1:0];
      end
   end

   // events: rising edges of hard stop and both pins
   always_comb begin
      irq_events                    = 3'h0;
      irq_events[GCR_IRQ_HARD_STOP] = hard_stop && !standstill_ff;
      irq_events[GCR_IRQ_PIN1_RISE] = nxt_pin1 && !pin1_ff;
      irq_events[GCR_IRQ_PIN0_RISE] = nxt_pin0 && !pin0_ff;
      irq_clear = (wr_en && paddr == GCR_ADDR_IRQ_STATUS) ? pwdata[GCR_IRQ_W-1:0] : 3'h0;
   end

   // sticky status, write one to clear, a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_ff <= GCR_IRQ_RST;
      end else begin
         irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_status_ff & irq_mask_ff);
      end
   end

   // diagnostic pins registered from the routing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin1_ff <= 1'b0;
         pin0_ff <= 1'b0;
      end else begin
         pin1_ff <= nxt_pin1;
         pin0_ff <= nxt_pin0;
      end
   end

   // axis-1 step source and hard stop
   always_comb begin
      hard_stop = cfg_ff.axis1_hard_stop_enable && enc_a;
      sel_step  = cfg_ff.axis1_external_step_mode ? ext_step : ctrl.axis1_int_step;
      sel_dir   = cfg_ff.axis1_external_step_mode ? ext_dir : ctrl.axis1_int_dir;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_dis_ff    <= GCR_GLOBAL_CONFIGURATION_RST[28];
         int_en_ff     <= 1'b1;
         step_ff       <= 1'b0;
         dir_ff        <= 1'b0;
         standstill_ff <= 1'b0;
      end else begin
         drv_dis_ff    <= cfg_ff.axis1_driver_disable;
         int_en_ff     <= !cfg_ff.axis1_external_step_mode;
         step_ff       <= hard_stop ? 1'b0 : sel_step;
         dir_ff        <= sel_dir;
         standstill_ff <= hard_stop;
      end
   end

   // hysteresis for step frequency comparison
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hyst_ff <= GCR_HYST_SHIFT_16;
      end else begin
         hyst_ff <= cfg_ff.axis1_hysteresis_select ? GCR_HYST_SHIFT_32 : GCR_HYST_SHIFT_16;
      end
   end

   // direct coil current mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direct_ff   <= 1'b0;
         auto_cur_ff <= 1'b1;
         coil_a_ff   <= 9'h000;
         coil_b_ff   <= 9'h000;
      end else begin
         direct_ff   <= cfg_ff.axis1_coil_current_direct;
         auto_cur_ff <= !cfg_ff.axis1_coil_current_direct;
         if (cfg_ff.axis1_coil_current_direct) begin
            coil_a_ff <= gcr_scale(axis1_target_position[GCR_COIL_A_MSB:GCR_COIL_A_LSB],
                                   hold_current_scale);
            coil_b_ff <= gcr_scale(axis1_target_position[GCR_COIL_B_MSB:GCR_COIL_B_LSB],
                                   hold_current_scale);
         end else begin
            coil_a_ff <= 9'h000;
            coil_b_ff <= 9'h000;
         end
      end
   end

   assign prdata                     = prdata_ff;
   assign pready                     = pready_ff;
   assign pslverr                    = pslverr_ff;
   assign irq                        = irq_ff;
   assign stall_index_pin            = pin1_ff;
   assign error_status_pin           = pin0_ff;
   assign axis1_driver_disable       = drv_dis_ff;
   assign axis1_internal_ctrl_enable = int_en_ff;
   assign axis1_step_out             = step_ff;
   assign axis1_dir_out              = dir_ff;
   assign axis1_standstill           = standstill_ff;
   assign axis1_hyst_shift           = hyst_ff;
   assign axis1_direct_active        = direct_ff;
   assign axis1_auto_current_enable  = auto_cur_ff;
   assign axis1_coil_a               = coil_a_ff;
   assign axis1_coil_b               = coil_b_ff;
endmodule : gcr_top
`default_nettype wire

// ===== gcr_pkg.sv
// package with register map, field layout and helpers of the global configuration block
`default_nettype none
package gcr_pkg;

   // register byte addresses
   localparam logic [7:0]  GCR_ADDR_GLOBAL_CONFIGURATION      = 8'h00;
   localparam logic [7:0]  GCR_ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0]  GCR_ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  GCR_ADDR_STATE      = 8'h0C;

   // implemented field window of the configuration word
   localparam int          GCR_CFG_MSB         = 30;
   localparam int          GCR_CFG_LSB         = 19;
   localparam logic [31:0] GCR_GLOBAL_CONFIGURATION_RST       = 32'h1000_0000;
   localparam logic [11:0] GCR_CFG_RST         = 12'h200;

   // interrupt status bit positions and reset values
   localparam int          GCR_IRQ_W           = 3;
   localparam int          GCR_IRQ_HARD_STOP   = 0;
   localparam int          GCR_IRQ_PIN1_RISE   = 1;
   localparam int          GCR_IRQ_PIN0_RISE   = 2;
   localparam logic [2:0]  GCR_IRQ_RST         = 3'h0;

   // state register bit positions
   localparam int          GCR_ST_HARD_STOP    = 0;
   localparam int          GCR_ST_PIN1         = 1;
   localparam int          GCR_ST_PIN0         = 2;
   localparam int          GCR_ST_EXT_STEP     = 3;
   localparam int          GCR_ST_EXT_DIR      = 4;
   localparam int          GCR_ST_ENC_A        = 5;

   // coil fields of the axis-1 target word
   localparam int          GCR_COIL_A_MSB      = 8;
   localparam int          GCR_COIL_A_LSB      = 0;
   localparam int          GCR_COIL_B_MSB      = 24;
   localparam int          GCR_COIL_B_LSB      = 16;
   localparam int          GCR_COIL_W          = 9;
   localparam int          GCR_HOLD_W          = 5;
   localparam int          GCR_HOLD_SHIFT      = 5;
   localparam logic [9:0]  GCR_MSLUT_ZERO      = 10'h000;

   // step frequency comparison hysteresis as a right shift
   localparam logic [2:0]  GCR_HYST_SHIFT_16   = 3'h4;
   localparam logic [2:0]  GCR_HYST_SHIFT_32   = 3'h5;

   typedef enum logic [1:0] {
      GCR_CMB_OR    = 2'h0,
      GCR_CMB_AXIS0 = 2'h1,
      GCR_CMB_AXIS1 = 2'h2,
      GCR_CMB_AND   = 2'h3
   } gcr_combine_e;

   // field order matches bits 30 down to 19
   typedef struct packed {
      logic         pin1_source_select;
      logic         pin0_source_select;
      logic         axis1_driver_disable;
      logic         axis1_external_step_mode;
      logic         axis1_coil_current_direct;
      logic         axis1_hard_stop_enable;
      logic         axis1_hysteresis_select;
      logic         axis1_index_on_pin;
      gcr_combine_e compare_combine_select;
      gcr_combine_e interrupt_combine_select;
   } gcr_cfg_s;

   // status from both motion controllers and the driver
   typedef struct packed {
      logic       axis0_stall;
      logic       axis1_stall;
      logic       axis0_compare;
      logic       axis1_compare;
      logic       axis0_interrupt;
      logic       axis1_interrupt;
      logic       axis0_direction;
      logic       axis0_dir_on_pin;
      logic       driver_status;
      logic       axis1_int_step;
      logic       axis1_int_dir;
      logic [9:0] axis1_mslut_pos;
   } gcr_ctrl_s;

   function automatic logic gcr_combine(input gcr_combine_e sel, input logic a0,
                                        input logic a1);
      logic r;
      r = 1'b0;
      unique case (sel)
         GCR_CMB_OR:    r = a0 | a1;
         GCR_CMB_AXIS0: r = a0;
         GCR_CMB_AXIS1: r = a1;
         GCR_CMB_AND:   r = a0 & a1;
      endcase
      return r;
   endfunction : gcr_combine

   // coil * (hold + 1) / 32, signed
   function automatic logic [8:0] gcr_scale(input logic [8:0] coil, input logic [4:0] hold);
      logic signed [15:0] prod;
      logic signed [6:0]  fac;
      prod = 16'sh0000;
      fac  = $signed({1'b0, ({1'b0, hold} + 6'h01)});
      prod = 16'($signed(coil)) * 16'(fac);
      return prod[GCR_HOLD_SHIFT +: 9];
   endfunction : gcr_scale

endpackage : gcr_pkg
`default_nettype wire

// ===== gcr_sync.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
`timescale 1ns/10ps
module gcr_sync
   import gcr_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic dout_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // change counts once second and third stage agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_ff <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         dout_ff <= s3_ff;
      end
   end

   assign dout = dout_ff;
endmodule : gcr_sync
`default_nettype wire

// ===== gcr_route.sv
// diagnostic pin source selection from configuration and controller status
`default_nettype none
`timescale 1ns/10ps
module gcr_route
   import gcr_pkg::*;
(
   input  wire gcr_cfg_s  cfg,
   input  wire gcr_ctrl_s ctrl,
   output logic           nxt_pin1,
   output logic           nxt_pin0
);
   logic index_hit;
   logic cmp_comb;
   logic int_comb;

   always_comb begin
      index_hit = cfg.axis1_index_on_pin && (ctrl.axis1_mslut_pos == GCR_MSLUT_ZERO);
      cmp_comb  = gcr_combine(cfg.compare_combine_select, ctrl.axis0_compare,
                              ctrl.axis1_compare);
      int_comb  = gcr_combine(cfg.interrupt_combine_select, ctrl.axis0_interrupt,
                              ctrl.axis1_interrupt);
      if (!cfg.pin1_source_select) begin
         nxt_pin1 = ctrl.axis0_stall | ctrl.axis1_stall | index_hit;
      end else begin
         nxt_pin1 = ctrl.axis0_dir_on_pin ? ctrl.axis0_direction : cmp_comb;
      end
      nxt_pin0 = cfg.pin0_source_select ? int_comb : ctrl.driver_status;
   end
endmodule : gcr_route
`default_nettype wire

// ===== gcr_top_properties.sv
// port assertions of the global configuration block
`timescale 1ns/10ps
`default_nettype none
module gcr_props
   import gcr_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire gcr_ctrl_s   ctrl,
   input wire logic        axis1_driver_disable,
   input wire logic        axis1_internal_ctrl_enable,
   input wire logic        axis1_step_out,
   input wire logic        axis1_dir_out,
   input wire logic        axis1_standstill,
   input wire logic [2:0]  axis1_hyst_shift,
   input wire logic        axis1_direct_active,
   input wire logic        axis1_auto_current_enable,
   input wire logic [8:0]  axis1_coil_a,
   input wire logic [8:0]  axis1_coil_b
);
   logic gw;
   // configuration word write completing
   assign gw = psel & penable & pready & pwrite & (paddr == GCR_ADDR_GLOBAL_CONFIGURATION);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (
      psel && !penable |=> pready) else $error("no ready after setup");
   drv_disable_a: assert property (
      gw |-> ##2 axis1_driver_disable == $past(pwdata[28], 2))
      else $error("driver disable wrong");
   hyst_shift_a: assert property (
      gw |-> ##2 axis1_hyst_shift ==
      ($past(pwdata[24], 2) ? GCR_HYST_SHIFT_32 : GCR_HYST_SHIFT_16))
      else $error("hysteresis wrong");
   ext_mode_a: assert property (
      gw |-> ##2 axis1_internal_ctrl_enable == !$past(pwdata[27], 2))
      else $error("step mode wrong");
   direct_mode_a: assert property (
      gw |-> ##2 axis1_direct_active == $past(pwdata[26], 2) && axis1_auto_current_enable ==
      !$past(pwdata[26], 2)) else $error("direct mode wrong");
   coil_zero_a: assert property (
      !axis1_direct_active |-> axis1_coil_a == 9'h000 && axis1_coil_b == 9'h000)
      else $error("coil not zero");
   stop_step_a: assert property (
      axis1_standstill |-> !axis1_step_out) else $error("step during hard stop");
   int_step_a: assert property (
      axis1_internal_ctrl_enable ##1 axis1_internal_ctrl_enable && !axis1_standstill |->
      axis1_step_out == $past(ctrl.axis1_int_step) && axis1_dir_out == $past(ctrl.axis1_int_dir))
      else $error("internal step not passed");
endmodule : gcr_props
bind gcr_top gcr_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .ctrl(ctrl), .axis1_driver_disable(axis1_driver_disable),
   .axis1_internal_ctrl_enable(axis1_internal_ctrl_enable), .axis1_step_out(axis1_step_out),
   .axis1_dir_out(axis1_dir_out), .axis1_standstill(axis1_standstill),
   .axis1_hyst_shift(axis1_hyst_shift), .axis1_direct_active(axis1_direct_active),
   .axis1_auto_current_enable(axis1_auto_current_enable), .axis1_coil_a(axis1_coil_a),
   .axis1_coil_b(axis1_coil_b));
`default_nettype wire

// ===== tb_global_config_axis1_diag_routing.sv
// self-checking testbench of the global configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_global_config_axis1_diag_routing
   import gcr_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, axis1_target_position = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, rerr, e;
   gcr_ctrl_s   ctrl = '0, cv;
   logic [4:0]  hold_current_scale = 5'h00;
   logic        axis1_step_input = 1'b0, axis1_direction_input = 1'b0;
   logic        axis1_encoder_a_input = 1'b0;
   logic        stall_index_pin, error_status_pin, axis1_driver_disable;
   logic        axis1_internal_ctrl_enable, axis1_step_out, axis1_dir_out, axis1_standstill;
   logic [2:0]  axis1_hyst_shift;
   logic        axis1_direct_active, axis1_auto_current_enable;
   logic [8:0]  axis1_coil_a, axis1_coil_b;
   int          fails = 0, samples_checked = 0;
   logic [31:0] tt [3] = '{32'h01C0_0040, 32'h01C0_0040, 32'h0101_00FF};
   logic [4:0]  ht [3] = '{5'h1F, 5'h0F, 5'h0F};
   logic [17:0] et [3] = '{{9'h040, 9'h1C0}, {9'h020, 9'h1E0}, {9'h07F, 9'h180}};

   gcr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .ctrl(ctrl), .axis1_target_position(axis1_target_position),
      .hold_current_scale(hold_current_scale), .axis1_step_input(axis1_step_input),
      .axis1_direction_input(axis1_direction_input),
      .axis1_encoder_a_input(axis1_encoder_a_input), .stall_index_pin(stall_index_pin),
      .error_status_pin(error_status_pin), .axis1_driver_disable(axis1_driver_disable),
      .axis1_internal_ctrl_enable(axis1_internal_ctrl_enable), .axis1_step_out(axis1_step_out),
      .axis1_dir_out(axis1_dir_out), .axis1_standstill(axis1_standstill),
      .axis1_hyst_shift(axis1_hyst_shift), .axis1_direct_active(axis1_direct_active),
      .axis1_auto_current_enable(axis1_auto_current_enable), .axis1_coil_a(axis1_coil_a),
      .axis1_coil_b(axis1_coil_b));

   always #5 pclk = ~pclk;

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : wt

   task automatic pins(input logic [31:0] g, input gcr_ctrl_s v, input logic e1, input logic e0);
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, g);
      @(posedge pclk);
      ctrl <= v;
      wt(2);
      chk("stall_index_pin", 32'(e1), 32'(stall_index_pin));
      chk("error_status_pin", 32'(e0), 32'(error_status_pin));
   endtask : pins

   task automatic outs(input logic dd, input logic ie, input logic [2:0] hs, input logic da);
      chk("driver_disable", 32'(dd), 32'(axis1_driver_disable));
      chk("internal_ctrl", 32'(ie), 32'(axis1_internal_ctrl_enable));
      chk("hyst_shift", 32'(hs), 32'(axis1_hyst_shift));
      chk("auto_current", 32'(!da), 32'(axis1_auto_current_enable));
      chk("direct_active", 32'(da), 32'(axis1_direct_active));
   endtask : outs

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wt(0);
      outs(1'b1, 1'b1, 3'h4, 1'b0);
      apb(1'b0, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0000_0000);
      chk("global_configuration reset", GCR_GLOBAL_CONFIGURATION_RST, rd);
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, 32'hFFFF_FFFF);
      apb(1'b0, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0000_0000);
      chk("global_configuration ones", 32'h7FF8_0000, rd);
      outs(1'b1, 1'b0, 3'h5, 1'b1);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, 32'(rerr));
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0000_0000);
      wt(1);
      outs(1'b0, 1'b1, 3'h4, 1'b0);
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 4; k++) begin
            cv = '0;
            cv.axis0_compare = k[0];
            cv.axis0_interrupt = k[0];
            cv.axis1_compare = k[1];
            cv.axis1_interrupt = k[1];
            e = (s == 0) ? |k[1:0] : (s == 1) ? k[0] : (s == 2) ? k[1] : &k[1:0];
            pins(32'h6000_0000 | (32'(s) << 21) | (32'(s) << 19), cv, e, e);
         end
      end
      cv = '0;
      cv.axis0_stall = 1'b1;
      cv.driver_status = 1'b1;
      cv.axis1_mslut_pos = 10'h001;
      pins(32'h0000_0000, cv, 1'b1, 1'b1);
      cv.axis0_stall = 1'b0;
      cv.driver_status = 1'b0;
      cv.axis1_stall = 1'b1;
      pins(32'h0000_0000, cv, 1'b1, 1'b0);
      cv = '0;
      cv.axis0_compare = 1'b1;
      cv.axis0_interrupt = 1'b1;
      pins(32'h0000_0000, cv, 1'b0, 1'b0);
      pins(32'h0080_0000, cv, 1'b1, 1'b0);
      cv.axis1_mslut_pos = 10'h001;
      pins(32'h0080_0000, cv, 1'b0, 1'b0);
      cv = '0;
      cv.axis0_dir_on_pin = 1'b1;
      cv.axis0_direction = 1'b1;
      cv.axis1_int_step = 1'b1;
      cv.axis1_int_dir = 1'b1;
      pins(32'h4000_0000, cv, 1'b1, 1'b0);
      chk("int step", 32'h0000_0001, 32'(axis1_step_out));
      chk("int dir", 32'h0000_0001, 32'(axis1_dir_out));
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0800_0000);
      wt(1);
      chk("ext step idle", 32'h0000_0000, 32'(axis1_step_out));
      chk("ext dir idle", 32'h0000_0000, 32'(axis1_dir_out));
      @(posedge pclk);
      axis1_step_input <= 1'b1;
      axis1_direction_input <= 1'b1;
      wt(6);
      chk("ext step", 32'h0000_0001, 32'(axis1_step_out));
      chk("ext dir", 32'h0000_0001, 32'(axis1_dir_out));
      apb(1'b1, GCR_ADDR_IRQ_STATUS, 32'h0000_0007);
      apb(1'b1, GCR_ADDR_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0A00_0000);
      @(posedge pclk);
      axis1_encoder_a_input <= 1'b1;
      wt(6);
      chk("standstill", 32'h0000_0001, 32'(axis1_standstill));
      chk("stopped step", 32'h0000_0000, 32'(axis1_step_out));
      chk("irq on", 32'h0000_0001, 32'(irq));
      apb(1'b0, GCR_ADDR_IRQ_STATUS, 32'h0000_0000);
      chk("stop status", 32'h0000_0001, rd & 32'h0000_0001);
      apb(1'b0, GCR_ADDR_STATE, 32'h0000_0000);
      chk("state word", 32'h0000_0039, rd);
      apb(1'b1, GCR_ADDR_IRQ_MASK, 32'h0000_0000);
      wt(1);
      chk("irq masked", 32'h0000_0000, 32'(irq));
      @(posedge pclk);
      axis1_encoder_a_input <= 1'b0;
      wt(6);
      chk("released", 32'h0000_0001, 32'(axis1_step_out));
      apb(1'b1, GCR_ADDR_IRQ_STATUS, 32'h0000_0001);
      apb(1'b1, GCR_ADDR_IRQ_MASK, 32'h0000_0001);
      wt(1);
      chk("irq cleared", 32'h0000_0000, 32'(irq));
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0400_0000);
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         axis1_target_position <= tt[i];
         hold_current_scale <= ht[i];
         wt(2);
         chk("coil a", 32'(et[i][17:9]), 32'(axis1_coil_a));
         chk("coil b", 32'(et[i][8:0]), 32'(axis1_coil_b));
      end
      outs(1'b0, 1'b1, 3'h4, 1'b1);
      apb(1'b1, GCR_ADDR_GLOBAL_CONFIGURATION, 32'h0000_0000);
      wt(1);
      chk("coil off", 32'h0000_0000, 32'(axis1_coil_a));
      print_verdict();
   end

   initial begin
      #100_000;
      fails++;
      print_verdict();
   end
endmodule : tb_global_config_axis1_diag_routing
`default_nettype wire
